// >>> design/vic_top.sv
// module: vectored interrupt controller with ahb-lite register slave
`timescale 1ns/1ps
`default_nettype none
module vic_top import vic_pkg::*; (
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  input wire logic [NSRC-1:0] SRC_EVENT_I,
  input wire logic [7:0] UART_IRQ_STATUS_I,
  input wire logic [7:0] CONFIG_WORD_LOW_I,
  output logic CPU_IRQ_O,
  output logic CPU_IRQ_HIGH_O,
  output logic [VW-1:0] CPU_VECTOR_O,
  output logic [BASEW-1:0] CPU_VEC_ADDR_O,
  output logic IRQ_O
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic is_off(input logic [7:0] a, input logic [7:0] o);
    is_off = (a == o);
  endfunction : is_off

  logic [NSRC-1:0] flag_r;
  logic [NSRC-1:0] ena_r;
  logic [NSRC-1:0] prio_r;
  logic [7:0] ctrl_r;
  logic [BASEW-1:0] base_r;
  logic lock_r;
  logic lock_used_r;
  logic [7:0] cfg_r;
  logic cfg_taken_r;
  logic [NEV-1:0] irqs_r;
  logic [NEV-1:0] irqm_r;
  vic_state_t state_r;
  vic_cpu_t cpu_r;
  logic wr_ph_r;
  logic rd_ph_r;
  logic [7:0] addr_r;
  logic [31:0] rdata_nxt;
  logic [NSRC-1:0] pend;
  vic_pick_t pick_hi;
  vic_pick_t pick_lo;
  vic_pick_t pick;
  logic ack_low;
  logic ack_high;
  logic ack_ret;
  logic lock_err;
  logic wr_lock;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: zero wait states, always okay
  wire take = HSEL_I & HREADY_I & HTRANS_I[1];
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      wr_ph_r <= 1'b0;
      rd_ph_r <= 1'b0;
      addr_r <= 8'h00;
    end else begin
      wr_ph_r <= take & HWRITE_I;
      rd_ph_r <= take & ~HWRITE_I;
      addr_r <= take ? HADDR_I[7:0] : addr_r;
    end
  end

  wire wr = wr_ph_r;
  assign ack_low = wr & is_off(addr_r, OFF_ACK) & HWDATA_I[ACK_LOW];
  assign ack_high = wr & is_off(addr_r, OFF_ACK) & HWDATA_I[ACK_HIGH];
  assign ack_ret = wr & is_off(addr_r, OFF_ACK) & HWDATA_I[ACK_RET];
  assign wr_lock = wr & is_off(addr_r, OFF_LOCK);

  ////////////////////////////////////////////////////////////////////////////
  // config word caught once after reset release, then read-only
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cfg_r <= CFG_RESET;
      cfg_taken_r <= 1'b0;
    end else if (!cfg_taken_r) begin
      cfg_r <= CONFIG_WORD_LOW_I;
      cfg_taken_r <= 1'b1;
    end
  end

  // one-way lock
  // once locked with the one-way bit set, no write reopens the base
  wire unlock_ok = ~(cfg_r[CFG_ONEWAY] & lock_used_r);
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      lock_r <= 1'b0;
      lock_used_r <= 1'b0;
    end else if (wr_lock) begin
      if (HWDATA_I[LOCK_BIT]) begin
        lock_r <= 1'b1;
        lock_used_r <= 1'b1;
      end else if (unlock_ok) begin
        lock_r <= 1'b0;
      end
    end
  end

  assign lock_err = wr & is_off(addr_r, OFF_BASE) & lock_r;
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      base_r <= BASE_RESET;
    end else if (wr & is_off(addr_r, OFF_BASE) & ~lock_r) begin
      base_r <= HWDATA_I[BASEW-1:0];
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ena_r <= '0;
      prio_r <= '0;
      ctrl_r <= 8'h00;
      irqm_r <= '0;
    end else begin
      if (wr & is_off(addr_r, OFF_ENA)) ena_r <= HWDATA_I[NSRC-1:0];
      if (wr & is_off(addr_r, OFF_PRIO)) prio_r <= HWDATA_I[NSRC-1:0];
      if (wr & is_off(addr_r, OFF_CTRL)) ctrl_r <= HWDATA_I[7:0];
      if (wr & is_off(addr_r, OFF_IRQM)) irqm_r <= HWDATA_I[NEV-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags: hardware set wins over a software clear in the same cycle
  logic [NSRC-1:0] sw_mask;
  logic [NSRC-1:0] sw_clr;
  always_comb begin
    sw_mask = '0;
    sw_mask[FLAG3_LSB +: 8] = FLAG3_SWMASK;
    sw_mask[FLAG8_LSB +: 8] = FLAG8_MASK;
    sw_mask[FLAG9_LSB +: 8] = FLAG9_MASK;
    sw_clr = '0;
    if (wr & is_off(addr_r, OFF_FLAG3))
      sw_clr[FLAG3_LSB +: 8] = ~HWDATA_I[7:0];
    if (wr & is_off(addr_r, OFF_FLAG8))
      sw_clr[FLAG8_LSB +: 8] = ~HWDATA_I[7:0];
    if (wr & is_off(addr_r, OFF_FLAG9))
      sw_clr[FLAG9_LSB +: 8] = ~HWDATA_I[7:0];
    sw_clr = sw_clr & sw_mask;
  end

  // hardware-owned flags of register 3 follow their source level
  logic [NSRC-1:0] hw_lvl;
  always_comb begin
    hw_lvl = '0;
    hw_lvl[FLAG3_LSB +: 8] = FLAG3_HWMASK;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_flag
      always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
          flag_r[gi] <= 1'b0;
        end else if (gi == SRC_UART_GEN) begin
          flag_r[gi] <= |UART_IRQ_STATUS_I;
        end else if (hw_lvl[gi]) begin
          flag_r[gi] <= SRC_EVENT_I[gi];
        end else if (!sw_mask[gi]) begin
          flag_r[gi] <= 1'b0;
        end else if (SRC_EVENT_I[gi]) begin
          flag_r[gi] <= 1'b1;
        end else if (sw_clr[gi]) begin
          flag_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // enable gating
  assign pend = flag_r & ena_r;

  // fixed order: lowest index wins inside a level
  function automatic vic_pick_t first(input logic [NSRC-1:0] v,
                                      input logic hi);
    first.valid = 1'b0;
    first.high = hi;
    first.vec = VEC_NONE;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        first.valid = 1'b1;
        first.vec = VW'(i);
      end
    end
  endfunction : first

  // without priority mode all sources sit in the high level
  wire ipen = ctrl_r[CTRL_IPEN];
  assign pick_hi = first(pend & (ipen ? prio_r : '1), 1'b1);
  assign pick_lo = first(pend & (ipen ? ~prio_r : '0), 1'b0);

  // nesting: high may preempt active low, nothing preempts high
  wire hi_ok = ctrl_r[CTRL_GIEH] & (state_r != VIC_HIGH) &
               (state_r != VIC_HIGH_ON_LOW);
  wire lo_ok = ctrl_r[CTRL_GIEL] & ipen & (state_r == VIC_IDLE);
  always_comb begin
    pick = '{valid: 1'b0, high: 1'b0, vec: VEC_NONE};
    if (pick_hi.valid & hi_ok) pick = pick_hi;
    else if (pick_lo.valid & lo_ok) pick = pick_lo;
  end

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_r <= VIC_IDLE;
    end else begin
      case (state_r)
        VIC_IDLE: begin
          if (ack_high) state_r <= VIC_HIGH;
          else if (ack_low) state_r <= VIC_LOW;
        end
        VIC_LOW: begin
          if (ack_high) state_r <= VIC_HIGH_ON_LOW;
          else if (ack_ret) state_r <= VIC_IDLE;
        end
        VIC_HIGH_ON_LOW: if (ack_ret) state_r <= VIC_LOW;
        VIC_HIGH: if (ack_ret) state_r <= VIC_IDLE;
        default: state_r <= VIC_IDLE;
      endcase
    end
  end

  // single request, vector address, multi-vector select
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cpu_r <= '0;
    end else begin
      cpu_r.req <= pick.valid;
      cpu_r.high <= pick.high;
      cpu_r.vec <= pick.vec;
      if (cfg_r[CFG_MVEC])
        cpu_r.addr <= base_r + BASEW'({pick.vec, 1'b0});
      else
        cpu_r.addr <= base_r;
    end
  end

  assign CPU_IRQ_O = cpu_r.req;
  assign CPU_IRQ_HIGH_O = cpu_r.high;
  assign CPU_VECTOR_O = cpu_r.vec;
  assign CPU_VEC_ADDR_O = cpu_r.addr;

  ////////////////////////////////////////////////////////////////////////////
  // event status: set wins over read clear
  logic [NEV-1:0] ev;
  always_comb begin
    ev = '0;
    ev[EV_LOW] = ack_low & (state_r == VIC_IDLE);
    ev[EV_HIGH] = ack_high;
    ev[EV_LOCKERR] = lock_err;
  end
  wire rd_irqs = rd_ph_r & is_off(addr_r, OFF_IRQS);
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) irqs_r <= '0;
    else irqs_r <= ev | (rd_irqs ? '0 : irqs_r);
  end
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) IRQ_O <= 1'b0;
    else IRQ_O <= |(irqs_r & irqm_r);
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (addr_r)
      OFF_CTRL: rdata_nxt[7:0] = ctrl_r;
      OFF_STAT: rdata_nxt[1:0] = state_r;
      OFF_FLAG3: rdata_nxt[7:0] = flag_r[FLAG3_LSB +: 8];
      OFF_FLAG8: rdata_nxt[7:0] = flag_r[FLAG8_LSB +: 8] & FLAG8_MASK;
      OFF_FLAG9: rdata_nxt[7:0] = flag_r[FLAG9_LSB +: 8] & FLAG9_MASK;
      OFF_ENA: rdata_nxt[NSRC-1:0] = ena_r;
      OFF_PRIO: rdata_nxt[NSRC-1:0] = prio_r;
      OFF_BASE: rdata_nxt[BASEW-1:0] = base_r;
      OFF_LOCK: rdata_nxt[LOCK_BIT] = lock_r;
      OFF_CFG: rdata_nxt[7:0] = cfg_r;
      OFF_IRQS: rdata_nxt[NEV-1:0] = irqs_r;
      OFF_IRQM: rdata_nxt[NEV-1:0] = irqm_r;
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end
  assign HRDATA_O = rd_ph_r ? rdata_nxt : 32'h0000_0000;
endmodule : vic_top
`default_nettype wire

// >>> design/vic_pkg.sv
// package: vectored interrupt controller register map, types and constants
package vic_pkg;
  localparam int NSRC = 24;
  localparam int VW = 5;
  localparam int BASEW = 21;
  localparam logic [VW-1:0] VEC_NONE = 5'h1f;
  // byte offsets on the bus
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_FLAG3 = 8'h08;
  localparam logic [7:0] OFF_FLAG8 = 8'h0c;
  localparam logic [7:0] OFF_FLAG9 = 8'h10;
  localparam logic [7:0] OFF_ENA = 8'h14;
  localparam logic [7:0] OFF_PRIO = 8'h18;
  localparam logic [7:0] OFF_BASE = 8'h1c;
  localparam logic [7:0] OFF_LOCK = 8'h20;
  localparam logic [7:0] OFF_CFG = 8'h24;
  localparam logic [7:0] OFF_ACK = 8'h28;
  localparam logic [7:0] OFF_IRQS = 8'h2c;
  localparam logic [7:0] OFF_IRQM = 8'h30;
  // field positions
  localparam int CTRL_GIEH = 7;
  localparam int CTRL_GIEL = 6;
  localparam int CTRL_IPEN = 5;
  localparam int CFG_MVEC = 3;
  localparam int CFG_ONEWAY = 4;
  localparam int LOCK_BIT = 0;
  localparam int ACK_LOW = 0;
  localparam int ACK_HIGH = 1;
  localparam int ACK_RET = 2;
  // source index of each flag inside the 24-bit flag vector
  localparam int FLAG3_LSB = 0;
  localparam int FLAG8_LSB = 8;
  localparam int FLAG9_LSB = 16;
  localparam int SRC_UART_GEN = 6;
  localparam logic [7:0] FLAG3_SWMASK = 8'h80;
  localparam logic [7:0] FLAG3_HWMASK = 8'h3f;
  localparam logic [7:0] FLAG8_MASK = 8'hc0;
  localparam logic [7:0] FLAG9_MASK = 8'h0f;
  localparam logic [7:0] CFG_RESET = 8'h18;
  localparam logic [BASEW-1:0] BASE_RESET = 21'h000008;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int NEV = 3;
  localparam int EV_LOW = 0;
  localparam int EV_HIGH = 1;
  localparam int EV_LOCKERR = 2;

  typedef enum logic [1:0] {
    VIC_IDLE = 2'b00,
    VIC_LOW = 2'b01,
    VIC_HIGH_ON_LOW = 2'b11,
    VIC_HIGH = 2'b10
  } vic_state_t;

  typedef struct packed {
    logic valid;
    logic high;
    logic [VW-1:0] vec;
  } vic_pick_t;

  typedef struct packed {
    logic req;
    logic high;
    logic [VW-1:0] vec;
    logic [BASEW-1:0] addr;
  } vic_cpu_t;
endpackage : vic_pkg

// >>> test/vic_checker.sv
// checker: read data fields and cpu request relations
`timescale 1ns/1ps
`default_nettype none
module vic_checker import vic_pkg::*; (
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic HREADY_I,
  input wire logic [31:0] HRDATA_O,
  input wire logic [7:0] UART_IRQ_STATUS_I,
  input wire logic [7:0] CONFIG_WORD_LOW_I,
  input wire logic CPU_IRQ_O,
  input wire logic CPU_IRQ_HIGH_O,
  input wire logic [VW-1:0] CPU_VECTOR_O,
  input wire logic IRQ_O
);
  logic rd_r;
  logic [7:0] adr_r;
  // data phase tracker, only read phases matter
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rd_r <= 1'b0;
      adr_r <= 8'h00;
    end else if (HREADY_I) begin
      rd_r <= HSEL_I && HTRANS_I[1] && !HWRITE_I;
      adr_r <= HADDR_I[7:0];
    end
  end
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RSTN_I);
  chk_idle_vec_none: assert property (
    $past(RSTN_I) && !CPU_IRQ_O |-> CPU_VECTOR_O == VEC_NONE)
    else $error("idle vector wrong");
  chk_vec_in_range: assert property (
    CPU_IRQ_O |-> CPU_VECTOR_O < NSRC) else $error("vector out of range");
  chk_high_has_req: assert property (
    CPU_IRQ_HIGH_O |-> CPU_IRQ_O) else $error("high without request");
  chk_flag8_low_zero: assert property (
    rd_r && adr_r == OFF_FLAG8 |-> HRDATA_O[5:0] == 6'h00)
    else $error("flag8 unused bits set");
  chk_flag9_high_zero: assert property (
    rd_r && adr_r == OFF_FLAG9 |-> HRDATA_O[7:4] == 4'h0)
    else $error("flag9 unused bits set");
  chk_base_upper_zero: assert property (
    rd_r && adr_r == OFF_BASE |-> HRDATA_O[31:BASEW] == '0)
    else $error("base upper bits set");
  chk_uart_flag_or: assert property (
    rd_r && adr_r == OFF_FLAG3 |-> HRDATA_O[6] == |$past(UART_IRQ_STATUS_I))
    else $error("uart flag not status or");
  chk_cfg_readback: assert property (
    rd_r && adr_r == OFF_CFG && $past(RSTN_I, 2)
    |-> HRDATA_O[7:0] == CONFIG_WORD_LOW_I) else $error("config readback");
  cover property (CPU_IRQ_O && CPU_IRQ_HIGH_O);
  cover property (CPU_IRQ_O && !CPU_IRQ_HIGH_O);
  cover property (IRQ_O);
endmodule : vic_checker
bind vic_top vic_checker i_chk (.SYS_CLK_I(SYS_CLK_I), .RSTN_I(RSTN_I),
  .HSEL_I(HSEL_I), .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I),
  .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O),
  .UART_IRQ_STATUS_I(UART_IRQ_STATUS_I), .IRQ_O(IRQ_O),
  .CONFIG_WORD_LOW_I(CONFIG_WORD_LOW_I), .CPU_IRQ_O(CPU_IRQ_O),
  .CPU_IRQ_HIGH_O(CPU_IRQ_HIGH_O), .CPU_VECTOR_O(CPU_VECTOR_O));
`default_nettype wire

// >>> test/vic_cpu_model.sv
// cpu model: takes each new request after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module vic_cpu_model import vic_pkg::*; (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire vic_cpu_t cpu_i,
  input wire logic [1:0] dly_i,
  output logic take_o,
  output var vic_cpu_t seen_o
);
  logic [2:0] cnt_r;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= 3'h0;
      take_o <= 1'b0;
      seen_o <= '0;
    end else begin
      take_o <= 1'b0;
      cnt_r <= 3'h0;
      if (!cpu_i.req) begin
        seen_o <= '0;
      end else if (cpu_i != seen_o) begin
        cnt_r <= cnt_r + 3'h1;
        if (cnt_r >= {1'b0, dly_i}) begin
          take_o <= 1'b1;
          seen_o <= cpu_i;
        end
      end
    end
  end
endmodule : vic_cpu_model
`default_nettype wire

// >>> test/vic_top_tb.sv
// testbench: bus tasks, cpu model, queued result checks
`timescale 1ns/1ps
`default_nettype none
module vic_top_tb import vic_pkg::*;;
  logic clk = 0;
  logic rstn = 0;
  logic hsel = 0;
  logic [31:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic hwrite = 0;
  logic [31:0] hwdata = 0;
  logic [NSRC-1:0] src = 0;
  logic [7:0] uart = 0;
  logic [31:0] hrdata;
  logic hready;
  logic irq;
  logic take;
  logic [1:0] dly = 0;
  logic rd_ph = 0;
  vic_cpu_t cpu;
  vic_cpu_t seen;
  logic [31:0] rq[$];
  vic_cpu_t iq[$];
  logic [31:0] rnd = 32'h0001_160d;
  logic [7:0] cfg = 8'h18;
  logic mv = 1'b1;
  logic [20:0] b;
  int num_errors = 0;
  int num_checks = 0;
  always #12.5 clk = ~clk;
  vic_top i_dut (.SYS_CLK_I(clk), .RSTN_I(rstn), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(HSIZE_WORD), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(),
    .SRC_EVENT_I(src), .UART_IRQ_STATUS_I(uart), .IRQ_O(irq),
    .CONFIG_WORD_LOW_I(cfg), .CPU_IRQ_O(cpu.req),
    .CPU_IRQ_HIGH_O(cpu.high), .CPU_VECTOR_O(cpu.vec),
    .CPU_VEC_ADDR_O(cpu.addr));
  vic_cpu_model i_cpu (.clk_i(clk), .rstn_i(rstn), .cpu_i(cpu),
    .dly_i(dly), .take_o(take), .seen_o(seen));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic ev(input logic [NSRC-1:0] m);
    src <= m;
    @(posedge clk);
    src <= '0;
  endtask : ev
  // expected request: base, plus two per vector in multi-vector mode
  task automatic xi(input logic hi, input logic [4:0] v);
    iq.push_back({1'b1, hi, v, b + (mv ? {15'h0, v, 1'b0} : 21'h0)});
    rnd = lfsr(rnd);
    dly <= rnd[1:0];
  endtask : xi
  task automatic wt();
    for (int i = 0; i < 12 && !take; i++) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask : wt
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (rd_ph && hready) check(hrdata, rq.size() ? rq.pop_front() : 'x);
    if (take) check({4'h0, seen}, iq.size() ? {4'h0, iq.pop_front()} : 'x);
    if (hready) rd_ph <= hsel && htrans[1] && !hwrite;
  end
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(OFF_CFG, 32'h18);
    rd(OFF_BASE, {11'h0, BASE_RESET});
    rnd = lfsr(rnd);
    b = rnd[20:0];
    wr(OFF_IRQM, 32'h4);
    wr(OFF_BASE, rnd);
    wr(OFF_LOCK, 32'h1);
    wr(OFF_BASE, ~rnd);
    rd(OFF_BASE, {11'h0, b});
    #1 check({31'h0, irq}, 32'h1);
    rd(OFF_IRQS, 32'h4);
    repeat (2) @(posedge clk);
    #1 check({31'h0, irq}, 32'h0);
    wr(OFF_LOCK, 32'h0);
    rd(OFF_LOCK, 32'h1);
    ev(24'h0fc000);
    rd(OFF_FLAG8, 32'hc0);
    rd(OFF_FLAG9, 32'h0f);
    #1 check({31'h0, cpu.req}, 32'h0);
    wr(OFF_FLAG8, 32'h0);
    wr(OFF_FLAG9, 32'h0);
    rd(OFF_FLAG9, 32'h0);
    uart <= 8'h21;
    repeat (2) @(posedge clk);
    wr(OFF_FLAG3, 32'h0);
    rd(OFF_FLAG3, 32'h40);
    uart <= 8'h0;
    repeat (2) @(posedge clk);
    rd(OFF_FLAG3, 32'h0);
    // mixed levels, lowest vector first, nesting
    wr(OFF_CTRL, 32'he0);
    wr(OFF_PRIO, 32'h020000);
    wr(OFF_ENA, 32'h034000);
    xi(1'b1, 5'd17);
    ev(24'h034000);
    wt();
    wr(OFF_ACK, 32'h2);
    rd(OFF_STAT, 32'h2);
    wr(OFF_FLAG9, 32'h0d);
    xi(1'b0, 5'd14);
    wr(OFF_ACK, 32'h4);
    wt();
    wr(OFF_ACK, 32'h1);
    xi(1'b1, 5'd17);
    ev(24'h020000);
    wt();
    wr(OFF_ACK, 32'h2);
    rd(OFF_STAT, 32'h3);
    wr(OFF_FLAG9, 32'h0d);
    wr(OFF_ACK, 32'h4);
    rd(OFF_STAT, 32'h1);
    wr(OFF_FLAG8, 32'h0);
    xi(1'b0, 5'd16);
    wr(OFF_ACK, 32'h4);
    wt();
    wr(OFF_ACK, 32'h1);
    wr(OFF_FLAG9, 32'h0);
    wr(OFF_ACK, 32'h4);
    rd(OFF_STAT, 32'h0);
    rd(OFF_IRQS, 32'h3);
    // second reset: one shared vector, lock may be reopened
    cfg <= 8'h00;
    mv = 1'b0;
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(OFF_CFG, 32'h0);
    wr(OFF_LOCK, 32'h1);
    wr(OFF_LOCK, 32'h0);
    rd(OFF_LOCK, 32'h0);
    rnd = lfsr(rnd);
    b = rnd[20:0];
    wr(OFF_BASE, rnd);
    wr(OFF_CTRL, 32'h80);
    wr(OFF_ENA, 32'h80);
    xi(1'b1, 5'd7);
    ev(24'h000080);
    wt();
    rd(OFF_FLAG3, 32'h80);
    wr(OFF_FLAG3, 32'h0);
    rd(OFF_FLAG3, 32'h0);
    // let the monitor pop the last read before counting leftovers
    @(posedge clk);
    check(32'(iq.size() + rq.size()), 32'h0);
    final_report();
  end
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    final_report();
  end
endmodule : vic_top_tb
`default_nettype wire
